/* File: src/adc_input_channel_select.sv */
// Input select, scan mask and conversion clock registers behind an AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "adc_sel_cfg.svh"

module adc_input_channel_select
    import adc_sel_pkg::*;
#(
    parameter int DIV_W = `CONV_DIV_WIDTH // Width of conversion_clock_divisor
) (
    input  wire logic        clk,                   // System (oscillator) clock
    input  wire logic        rst_n,                 // Asynchronous reset, active low
    input  wire logic [11:0] s_axi_awaddr,          // Write address
    input  wire logic        s_axi_awvalid,         // Write address valid
    output logic             s_axi_awready,         // Write address ready
    input  wire logic [31:0] s_axi_wdata,           // Write data
    input  wire logic [3:0]  s_axi_wstrb,           // Write byte strobes
    input  wire logic        s_axi_wvalid,          // Write data valid
    output logic             s_axi_wready,          // Write data ready
    output logic [1:0]       s_axi_bresp,           // Write response
    output logic             s_axi_bvalid,          // Write response valid
    input  wire logic        s_axi_bready,          // Write response ready
    input  wire logic [11:0] s_axi_araddr,          // Read address
    input  wire logic        s_axi_arvalid,         // Read address valid
    output logic             s_axi_arready,         // Read address ready
    output logic [31:0]      s_axi_rdata,           // Read data
    output logic [1:0]       s_axi_rresp,           // Read response
    output logic             s_axi_rvalid,          // Read data valid
    input  wire logic        s_axi_rready,          // Read data ready
    output logic [3:0]       mux_a_ext_index,       // Setting A external input number
    output logic             mux_a_ext_en,          // Setting A routes an external input
    output logic             mux_a_bandgap,         // Setting A routes full band gap
    output logic             mux_a_bandgap_half,    // Setting A routes half band gap
    output logic             mux_a_neg_input1,      // Setting A negative side is input 1
    output logic [3:0]       mux_b_ext_index,       // Setting B external input number
    output logic             mux_b_ext_en,          // Setting B routes an external input
    output logic             mux_b_bandgap,         // Setting B routes full band gap
    output logic             mux_b_bandgap_half,    // Setting B routes half band gap
    output logic             mux_b_neg_input1,      // Setting B negative side is input 1
    output logic [15:0]      scan_channel_select,   // Scan mask, bit n takes input n
    output logic             conv_clk_tick          // One pulse per conversion clock period
);

    // ==========================================================
    // Registers and bus state
    logic [15:0]      sel_r;
    logic [15:0]      scan_r;
    logic [DIV_W-1:0] div_r;
    logic [11:0]      awaddr_r;
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;
    logic             aw_have_r;
    logic             w_have_r;
    logic             osc_phase_r;
    logic [DIV_W-1:0] instr_cnt_r;
    pos_kind_t        kind_a;
    pos_kind_t        kind_b;
    logic [3:0]       idx_a;
    logic [3:0]       idx_b;
    logic             neg_a;
    logic             neg_b;
    logic             wr_fire;
    logic             instr_tick;

    // Merge one byte lane under its strobe and a write mask
    function automatic logic [7:0] lane(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic en, input logic [7:0] msk);
        lane = en ? (new_v & msk) : old_v;
    endfunction

    // Known register address check
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `OFS_INPUT_MUX_SELECT) || (a == `OFS_SCAN_INPUT_MASK) ||
                 (a == `OFS_CONV_CLOCK_DIV) || (a == `OFS_SELECT_STATUS);
    endfunction

    // ==========================================================
    // Write address and data are caught separately, in either order
    assign wr_fire = aw_have_r && w_have_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= 12'h000;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            // Ready is raised only while the slot is empty and no answer is owed
            s_axi_awready <= !aw_have_r && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_r && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // Write response one edge after both halves are held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Register file; upper bus lanes have no storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r  <= `RST_INPUT_MUX_SELECT;
            scan_r <= `RST_SCAN_INPUT_MASK;
            div_r  <= '0;
        end else if (wr_fire) begin
            unique case (awaddr_r)
                `OFS_INPUT_MUX_SELECT: begin
                    // Unimplemented bits stay zero
                    sel_r <= {lane(sel_r[15:8], wdata_r[15:8], wstrb_r[1],
                                   `MUX_SELECT_WR_MASK_HI),
                              lane(sel_r[7:0], wdata_r[7:0], wstrb_r[0],
                                   `MUX_SELECT_WR_MASK_LO)};
                end
                `OFS_SCAN_INPUT_MASK: begin
                    scan_r <= {lane(scan_r[15:8], wdata_r[15:8], wstrb_r[1], 8'hFF),
                               lane(scan_r[7:0], wdata_r[7:0], wstrb_r[0], 8'hFF)};
                end
                `OFS_CONV_CLOCK_DIV: begin
                    if (wstrb_r[0]) begin
                        div_r <= wdata_r[DIV_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Read channel; unmapped addresses read zero with an error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                unique case (s_axi_araddr)
                    `OFS_INPUT_MUX_SELECT: s_axi_rdata <= {16'h0000, sel_r};
                    `OFS_SCAN_INPUT_MASK:  s_axi_rdata <= {16'h0000, scan_r};
                    `OFS_CONV_CLOCK_DIV:   s_axi_rdata <= 32'(div_r);
                    `OFS_SELECT_STATUS:    s_axi_rdata <= {28'h000_0000, conv_clk_tick,
                                                           osc_phase_r,
                                                           kind_b == POS_BAD,
                                                           kind_a == POS_BAD};
                    default:               s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Code decoders for the two settings
    adc_mux_decode u_dec_a (
        .pos_code   (sel_r[`FLD_MUX_A_POS_HI:`FLD_MUX_A_POS_LO]),
        .neg_code   (sel_r[`FLD_MUX_A_NEG]),
        .pos_kind   (kind_a),
        .ext_index  (idx_a),
        .neg_input1 (neg_a)
    );

    adc_mux_decode u_dec_b (
        .pos_code   (sel_r[`FLD_MUX_B_POS_HI:`FLD_MUX_B_POS_LO]),
        .neg_code   (sel_r[`FLD_MUX_B_NEG]),
        .pos_kind   (kind_b),
        .ext_index  (idx_b),
        .neg_input1 (neg_b)
    );

    // Multiplexer steering is registered; a bad code routes nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {mux_a_ext_index, mux_a_ext_en, mux_a_bandgap, mux_a_bandgap_half} <= 7'h00;
            {mux_b_ext_index, mux_b_ext_en, mux_b_bandgap, mux_b_bandgap_half} <= 7'h00;
            mux_a_neg_input1 <= 1'b0;
            mux_b_neg_input1 <= 1'b0;
        end else begin
            mux_a_ext_index    <= idx_a;
            mux_a_ext_en       <= kind_a == POS_EXT;
            mux_a_bandgap      <= kind_a == POS_BG_FULL;
            mux_a_bandgap_half <= kind_a == POS_BG_HALF;
            mux_a_neg_input1   <= neg_a;
            mux_b_ext_index    <= idx_b;
            mux_b_ext_en       <= kind_b == POS_EXT;
            mux_b_bandgap      <= kind_b == POS_BG_FULL;
            mux_b_bandgap_half <= kind_b == POS_BG_HALF;
            mux_b_neg_input1   <= neg_b;
        end
    end

    // Scan mask drives the scan sequencer through one register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_channel_select <= 16'h0000;
        end else begin
            scan_channel_select <= scan_r;
        end
    end

    // ==========================================================
    // Conversion clock: instruction cycle is two clocks, divided by divisor+1
    assign instr_tick = osc_phase_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_phase_r   <= 1'b0;
            instr_cnt_r   <= '0;
            conv_clk_tick <= 1'b0;
        end else begin
            osc_phase_r   <= !osc_phase_r;
            conv_clk_tick <= 1'b0;
            if (instr_tick) begin
                // A lowered divisor takes effect at once, not after a wrap
                if (instr_cnt_r >= div_r) begin
                    instr_cnt_r   <= '0;
                    conv_clk_tick <= 1'b1;
                end else begin
                    instr_cnt_r <= instr_cnt_r + 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    logic [DIV_W+1:0] gap_r;
    logic             div_chg_r;
    logic             seen_r;
    logic             first_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r     <= '0;
            div_chg_r <= 1'b0;
            seen_r    <= 1'b0;
            first_r   <= 1'b1;
        end else begin
            first_r <= 1'b0;
            gap_r   <= conv_clk_tick ? '0 : gap_r + 1'b1;
            if (conv_clk_tick) begin
                seen_r <= 1'b1;
            end
            // A divisor write in a tick cycle must still mark the next period
            if (wr_fire && awaddr_r == `OFS_CONV_CLOCK_DIV) begin
                div_chg_r <= 1'b1;
            end else if (conv_clk_tick) begin
                div_chg_r <= 1'b0;
            end
        end
    end

    chk_neg_route: assert property (@(posedge clk) disable iff (!rst_n)
        !first_r
        |=> mux_a_neg_input1 == $past(sel_r[`FLD_MUX_A_NEG]) &&
            mux_b_neg_input1 == $past(sel_r[`FLD_MUX_B_NEG]))
        else $error("negative input routing does not follow select bits");

    chk_pos_ext: assert property (@(posedge clk) disable iff (!rst_n)
        !first_r && sel_r[4:0] <= `POS_CODE_LAST_EXT
        |=> mux_a_ext_en && !mux_a_bandgap && mux_a_ext_index == $past(sel_r[3:0]))
        else $error("external input not routed for code in range");

    chk_bandgap: assert property (@(posedge clk) disable iff (!rst_n)
        sel_r[12:8] == `POS_CODE_BG_FULL ##1 sel_r[12:8] == `POS_CODE_BG_HALF
        |-> mux_b_bandgap && !mux_b_bandgap_half ##1 mux_b_bandgap_half && !mux_b_ext_en)
        else $error("band gap codes misrouted");

    chk_scan_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_fire && awaddr_r == `OFS_SCAN_INPUT_MASK && wstrb_r[1:0] == 2'b11
        |-> ##2 scan_channel_select == $past(wdata_r[15:0], 2))
        else $error("scan mask write not reflected");

    chk_conv_period: assert property (@(posedge clk) disable iff (!rst_n)
        conv_clk_tick && seen_r && !div_chg_r
        |-> 32'(gap_r) == `OSC_PER_INSTR_CYCLE * (32'(div_r) + 1) - 1)
        else $error("conversion clock period wrong");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_INPUT_MUX_SELECT
        |=> s_axi_rvalid && s_axi_rdata[14:13] == 2'b00 && s_axi_rdata[6:5] == 2'b00)
        else $error("unimplemented select bits read nonzero");

    chk_reset_clear: assert property (@(posedge clk) disable iff (!rst_n)
        first_r |-> sel_r == 16'h0000 && scan_r == 16'h0000 && !s_axi_bvalid)
        else $error("registers not clear after reset");

    chk_write_resp: assert property (@(posedge clk) disable iff (!rst_n)
        wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response late");

endmodule // adc_input_channel_select

`default_nettype wire

/* File: src/adc_sel_cfg.svh */
// Offsets, field positions, reset values and timing counts of the input select block
`ifndef ADC_SEL_CFG_SVH
`define ADC_SEL_CFG_SVH

// ==========================================================
// Register byte addresses
`define OFS_INPUT_MUX_SELECT   12'h000
`define OFS_SCAN_INPUT_MASK    12'h004
`define OFS_CONV_CLOCK_DIV     12'h008
`define OFS_SELECT_STATUS      12'h00C

// ==========================================================
// Field positions in input_mux_select
`define FLD_MUX_B_NEG          15
`define FLD_MUX_B_POS_HI       12
`define FLD_MUX_B_POS_LO       8
`define FLD_MUX_A_NEG          7
`define FLD_MUX_A_POS_HI       4
`define FLD_MUX_A_POS_LO       0
`define MUX_SELECT_WR_MASK     16'h9F9F
`define MUX_SELECT_WR_MASK_HI  8'h9F
`define MUX_SELECT_WR_MASK_LO  8'h9F

// ==========================================================
// Positive input codes
`define POS_CODE_LAST_EXT      5'h0F
`define POS_CODE_BG_HALF       5'h10
`define POS_CODE_BG_FULL       5'h11

// ==========================================================
// Reset values and timing
`define RST_INPUT_MUX_SELECT   16'h0000
`define RST_SCAN_INPUT_MASK    16'h0000
`define CONV_DIV_WIDTH         8
`define OSC_PER_INSTR_CYCLE    2

`endif

/* File: src/adc_sel_pkg.sv */
// Types shared by the input select block
package adc_sel_pkg;

    // ==========================================================
    // Kind of source chosen by a positive-input code
    typedef enum logic [1:0] {
        POS_EXT     = 2'b00,
        POS_BG_HALF = 2'b01,
        POS_BG_FULL = 2'b11,
        POS_BAD     = 2'b10
    } pos_kind_t;

    // AXI response codes
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

endpackage

/* File: src/adc_mux_decode.sv */
// Decoder from one multiplexer setting code to multiplexer steering
`timescale 1ns/1ps
`default_nettype none
`include "adc_sel_cfg.svh"

module adc_mux_decode
    import adc_sel_pkg::*;
(
    input  wire logic [4:0] pos_code,  // Positive-input select code
    input  wire logic       neg_code,  // Negative-input select bit
    output var pos_kind_t   pos_kind,  // Decoded source kind
    output logic      [3:0] ext_index, // External input number
    output logic            neg_input1 // High routes external input 1 to the negative side
);

    // ==========================================================
    // Positive source; unimplemented codes are flagged, not routed
    always_comb begin
        ext_index = pos_code[3:0];
        if (pos_code <= `POS_CODE_LAST_EXT) begin
            pos_kind = POS_EXT;
        end else if (pos_code == `POS_CODE_BG_HALF) begin
            pos_kind = POS_BG_HALF;
        end else if (pos_code == `POS_CODE_BG_FULL) begin
            pos_kind = POS_BG_FULL;
        end else begin
            pos_kind = POS_BAD;
        end
    end

    // Negative source: input 1 when set, negative reference when clear
    assign neg_input1 = neg_code;

endmodule // adc_mux_decode

`default_nettype wire

/* File: dv/analog_mux_model.sv */
// Behavioural model of the analog multiplexer that one setting steers
`timescale 1ns/1ps
`default_nettype none

module analog_mux_model (
    input  wire logic       ext_en,        // Route an external input
    input  wire logic [3:0] ext_index,     // External input number
    input  wire logic       bandgap,       // Route full band gap
    input  wire logic       bandgap_half,  // Route half band gap
    input  wire logic       neg_input1,    // Negative side from input 1
    output logic      [4:0] routed_src,    // Source seen on the positive side
    output logic            neg_is_input1  // Source seen on the negative side
);
    // ==========
    // Positive side: 0..15 external, 16 half, 17 full, 30 clash, 31 open
    always_comb begin
        case ({ext_en, bandgap, bandgap_half})
            3'b100:  routed_src = {1'b0, ext_index};
            3'b010:  routed_src = 5'h11;
            3'b001:  routed_src = 5'h10;
            3'b000:  routed_src = 5'h1F;
            default: routed_src = 5'h1E;             // Two or more sources shorted together
        endcase
    end

    // Negative side: input 1 or negative reference
    assign neg_is_input1 = neg_input1;
endmodule // analog_mux_model

`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the input select, scan mask and conversion clock registers
`timescale 1ns/1ps
`default_nettype none
`include "adc_sel_cfg.svh"

module tb_top
    import adc_sel_pkg::*;
;

    localparam int BG_SETTLE_CYC = 20; // Software pause before band gap use

    logic        clk, rst_n;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, wd;
    logic [3:0]  s_axi_wstrb, mux_a_ext_index, mux_b_ext_index;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, conv_clk_tick;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        mux_a_ext_en, mux_a_bandgap, mux_a_bandgap_half, mux_a_neg_input1;
    logic        mux_b_ext_en, mux_b_bandgap, mux_b_bandgap_half, mux_b_neg_input1;
    logic [15:0] scan_channel_select;
    logic [4:0]  src_a, src_b;
    logic        neg_a, neg_b;
    logic [15:0] pats [2] = '{16'hA5C3, 16'h5A3C};
    int          errors, total_checks, n;

    // ==========
    // Design and the two multiplexer models
    adc_input_channel_select #(.DIV_W(8)) i_adc_input_channel_select (
        .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mux_a_ext_index, .mux_a_ext_en,
        .mux_a_bandgap, .mux_a_bandgap_half, .mux_a_neg_input1, .mux_b_ext_index,
        .mux_b_ext_en, .mux_b_bandgap, .mux_b_bandgap_half, .mux_b_neg_input1,
        .scan_channel_select, .conv_clk_tick);
    analog_mux_model i_analog_mux_model_a (.ext_en(mux_a_ext_en),
        .ext_index(mux_a_ext_index), .bandgap(mux_a_bandgap),
        .bandgap_half(mux_a_bandgap_half), .neg_input1(mux_a_neg_input1),
        .routed_src(src_a), .neg_is_input1(neg_a));
    analog_mux_model i_analog_mux_model_b (.ext_en(mux_b_ext_en),
        .ext_index(mux_b_ext_index), .bandgap(mux_b_bandgap),
        .bandgap_half(mux_b_bandgap_half), .neg_input1(mux_b_neg_input1),
        .routed_src(src_b), .neg_is_input1(neg_b));

    // ==========
    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Ready is registered, so its level at the falling edge is what the next edge sees
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        logic aw_done, w_done, ta, tw;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge clk);
            ta = !aw_done && s_axi_awready === 1'b1;
            tw = !w_done && s_axi_wready === 1'b1;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            aw_done = aw_done || ta;
            w_done = w_done || tw;
        end
        do @(negedge clk); while (s_axi_bvalid !== 1'b1);
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (s_axi_arready !== 1'b1);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (s_axi_rvalid !== 1'b1);
        check("rdata", ed, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    // Skips to a tick, then counts clocks up to the following one
    task automatic tick_period(output int cnt);
        cnt = 0;
        do @(negedge clk); while (conv_clk_tick !== 1'b1);
        do begin
            @(negedge clk);
            cnt++;
        end while (conv_clk_tick !== 1'b1);
    endtask

    // ==========
    // Main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        axi_read(`OFS_INPUT_MUX_SELECT, 32'h0, RESP_OKAY);
        axi_read(`OFS_SCAN_INPUT_MASK, 32'h0, RESP_OKAY);
        check("reset src_a", 32'h0, {27'h0, src_a});
        check("reset neg_b", 32'h0, {31'h0, neg_b});
        // Both settings through every implemented code; unused bits written as ones
        for (int c = 0; c < 18; c++) begin
            wd = {16'h0, c[0], 2'b11, 5'(17 - c), ~c[0], 2'b11, 5'(c)};
            axi_write(`OFS_INPUT_MUX_SELECT, wd, 4'b0011, RESP_OKAY);
            if (c >= 16 || c <= 1) repeat (BG_SETTLE_CYC) @(posedge clk);
            axi_read(`OFS_INPUT_MUX_SELECT, wd & 32'h0000_9F9F, RESP_OKAY);
            check("src_a", 32'(c), {27'h0, src_a});
            check("src_b", 32'(17 - c), {27'h0, src_b});
            check("neg_a", {31'h0, ~c[0]}, {31'h0, neg_a});
            check("neg_b", {31'h0, c[0]}, {31'h0, neg_b});
        end
        // Scan mask patterns, then a single upper-lane write
        for (int i = 0; i < 2; i++) begin
            axi_write(`OFS_SCAN_INPUT_MASK, {16'h0, pats[i]}, 4'hF, RESP_OKAY);
            @(negedge clk);
            check("scan", {16'h0, pats[i]}, {16'h0, scan_channel_select});
            axi_read(`OFS_SCAN_INPUT_MASK, {16'h0, pats[i]}, RESP_OKAY);
        end
        axi_write(`OFS_SCAN_INPUT_MASK, 32'h0000_FF11, 4'b0010, RESP_OKAY);
        @(negedge clk);
        check("scan lane", 32'h0000_FF3C, {16'h0, scan_channel_select});
        // Unmapped address is refused and leaves the mask alone
        axi_write(12'h010, 32'h0000_1234, 4'hF, RESP_SLVERR);
        axi_read(12'h010, 32'h0, RESP_SLVERR);
        axi_read(`OFS_SCAN_INPUT_MASK, 32'h0000_FF3C, RESP_OKAY);
        // Conversion clock: first period after a change may be short, so measure the one from the third tick to the fourth
        foreach (pats[i]) begin
            wd = (i == 0) ? 32'h0 : 32'h5;
            axi_write(`OFS_CONV_CLOCK_DIV, wd, 4'b0001, RESP_OKAY);
            axi_read(`OFS_CONV_CLOCK_DIV, wd, RESP_OKAY);
            tick_period(n);
            tick_period(n);
            check("tick period", 32'(`OSC_PER_INSTR_CYCLE * (wd + 1)), 32'(n));
        end
        // Second reset in mid-run clears everything written so far
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        axi_read(`OFS_INPUT_MUX_SELECT, 32'h0, RESP_OKAY);
        axi_read(`OFS_SCAN_INPUT_MASK, 32'h0, RESP_OKAY);
        check("scan after reset", 32'h0, {16'h0, scan_channel_select});
        final_report();
    end

    // Watchdog well beyond the few hundred clocks the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule // tb_top

`default_nettype wire
